/* File: src/gpio_drive_pkg.sv */
// Purpose: constants and types for the port drive register block
// Assumes: byte-wide register bus, one register per index
// Notes:   offsets are register indices on the plain port
package gpio_drive_pkg;
    localparam int unsigned PIN_COUNT  = 8;
    localparam int unsigned ADDR_WIDTH = 5;

    localparam logic [ADDR_WIDTH-1:0] OFS_DRIVE_ENABLE    = 5'h00;
    localparam logic [ADDR_WIDTH-1:0] OFS_ENABLE_SET      = 5'h01;
    localparam logic [ADDR_WIDTH-1:0] OFS_ENABLE_CLEAR    = 5'h02;
    localparam logic [ADDR_WIDTH-1:0] OFS_ENABLE_TOGGLE   = 5'h03;
    localparam logic [ADDR_WIDTH-1:0] OFS_DRIVE_LEVEL     = 5'h04;
    localparam logic [ADDR_WIDTH-1:0] OFS_LEVEL_SET       = 5'h05;
    localparam logic [ADDR_WIDTH-1:0] OFS_LEVEL_CLEAR     = 5'h06;
    localparam logic [ADDR_WIDTH-1:0] OFS_LEVEL_TOGGLE    = 5'h07;
    // per-pin invert and input-buffer enable, one bit per pin
    localparam logic [ADDR_WIDTH-1:0] OFS_POLARITY_INVERT = 5'h10;
    localparam logic [ADDR_WIDTH-1:0] OFS_INPUT_SENSE_EN  = 5'h11;

    localparam logic [PIN_COUNT-1:0] RST_BYTE    = 8'h00;
    localparam logic [PIN_COUNT-1:0] UNMAPPED_RD = 8'h00;

    typedef struct packed {
        logic [ADDR_WIDTH-1:0] addr;
        logic [PIN_COUNT-1:0]  wdata;
        logic                  wr;
        logic                  rd;
    } reg_req_t;

    typedef struct packed {
        logic [PIN_COUNT-1:0] level;
        logic [PIN_COUNT-1:0] enable;
    } pin_drive_t;
endpackage

/* File: src/gpio_port_drive_regs.sv */
// Purpose: drive-enable and drive-level registers of an 8-pin port
// Assumes: register strobes are one cycle and synchronous to i_clk
// Notes:   read data stand in the cycle after the read strobe only
`timescale 1ns/1ps

// How it works
// - drive-enable bit one enables pin driver; zero makes pin input-only
// - drive-enable never touches the input buffer; input-sense bits do
// - one written to enable-set sets that drive-enable bit
// - one written to enable-clear clears that drive-enable bit
// - one written to enable-toggle inverts that drive-enable bit
// - zero bits in set, clear, toggle writes leave targets unchanged
// - reading enable set, clear or toggle returns drive-enable
// - drive-level bit one drives pin high, zero drives low
// - drive-level reaches the pin only while its driver is enabled
// - one written to level-set sets that drive-level bit
// - one written to level-clear clears that drive-level bit
// - one written to level-toggle inverts that drive-level bit
// - reading level set, clear or toggle returns drive-level
// - set, clear and toggle writes change only the selected bits; a direct write replaces the whole byte
// - active inversion flips both driven and sampled pin values
module gpio_port_drive_regs
    import gpio_drive_pkg::*;
(
    input  wire logic                                i_clk,
    input  wire logic                                i_rst_n,
    input  wire gpio_drive_pkg::reg_req_t            i_req,
    input  wire logic [gpio_drive_pkg::PIN_COUNT-1:0] i_pin_in,
    output logic      [gpio_drive_pkg::PIN_COUNT-1:0] o_rdata,
    output logic      [gpio_drive_pkg::PIN_COUNT-1:0] o_pin_out,
    output logic      [gpio_drive_pkg::PIN_COUNT-1:0] o_pin_oe,
    output logic      [gpio_drive_pkg::PIN_COUNT-1:0] o_in_buf_en,
    output logic      [gpio_drive_pkg::PIN_COUNT-1:0] o_pin_sample
);
    import gpio_drive_pkg::*;

    logic [PIN_COUNT-1:0] enable_q;
    logic [PIN_COUNT-1:0] enable_d;
    logic [PIN_COUNT-1:0] level_q;
    logic [PIN_COUNT-1:0] level_d;
    logic [PIN_COUNT-1:0] invert_q;
    logic [PIN_COUNT-1:0] sense_en_q;
    logic [PIN_COUNT-1:0] invert_d;
    logic [PIN_COUNT-1:0] sense_d;
    logic [PIN_COUNT-1:0] rdata_d;
    pin_drive_t           drive_d;

    logic wr_en;
    logic wr_lvl;
    assign wr_en  = i_req.wr && (i_req.addr inside {OFS_DRIVE_ENABLE,
                    OFS_ENABLE_SET, OFS_ENABLE_CLEAR, OFS_ENABLE_TOGGLE});
    assign wr_lvl = i_req.wr && (i_req.addr inside {OFS_DRIVE_LEVEL,
                    OFS_LEVEL_SET, OFS_LEVEL_CLEAR, OFS_LEVEL_TOGGLE});

    // one decode shape serves both words; set, clear, toggle move only selected bits
    function automatic logic [PIN_COUNT-1:0] modify(
        input logic [PIN_COUNT-1:0]  cur,
        input logic [PIN_COUNT-1:0]  wd,
        input logic [ADDR_WIDTH-1:0] ofs,
        input logic [ADDR_WIDTH-1:0] base
    );
        logic [PIN_COUNT-1:0] r;
        r = cur;
        if (ofs == base)
        begin
            r = wd;
        end
        else if (ofs == base + 5'h01)
        begin
            r = cur | wd;
        end
        else if (ofs == base + 5'h02)
        begin
            r = cur & ~wd;
        end
        else if (ofs == base + 5'h03)
        begin
            r = cur ^ wd;
        end
        return r;
    endfunction

    always_comb
    begin
        enable_d = enable_q;
        if (wr_en)
        begin
            enable_d = modify(enable_q, i_req.wdata, i_req.addr,
                              OFS_DRIVE_ENABLE);
        end
        level_d = level_q;
        if (wr_lvl)
        begin
            level_d = modify(level_q, i_req.wdata, i_req.addr,
                             OFS_DRIVE_LEVEL);
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            enable_q <= RST_BYTE;
            level_q  <= RST_BYTE;
        end
        else
        begin
            enable_q <= enable_d;
            level_q  <= level_d;
        end
    end

    // invert next value, so pins flip on the write edge
    always_comb
    begin
        invert_d = invert_q;
        sense_d  = sense_en_q;
        if (i_req.wr && i_req.addr == OFS_POLARITY_INVERT)
        begin
            invert_d = i_req.wdata;
        end
        if (i_req.wr && i_req.addr == OFS_INPUT_SENSE_EN)
        begin
            sense_d = i_req.wdata;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            invert_q   <= RST_BYTE;
            sense_en_q <= RST_BYTE;
        end
        else
        begin
            invert_q   <= invert_d;
            sense_en_q <= sense_d;
        end
    end

    always_comb
    begin
        unique case (i_req.addr)
            OFS_DRIVE_ENABLE, OFS_ENABLE_SET,
            OFS_ENABLE_CLEAR, OFS_ENABLE_TOGGLE: rdata_d = enable_q;
            OFS_DRIVE_LEVEL, OFS_LEVEL_SET,
            OFS_LEVEL_CLEAR, OFS_LEVEL_TOGGLE:   rdata_d = level_q;
            OFS_POLARITY_INVERT:                 rdata_d = invert_q;
            OFS_INPUT_SENSE_EN:                  rdata_d = sense_en_q;
            default:                             rdata_d = UNMAPPED_RD;
        endcase
    end

    // read data only in the cycle after the strobe, zero otherwise
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            o_rdata <= RST_BYTE;
        end
        else
        begin
            o_rdata <= i_req.rd ? rdata_d : RST_BYTE;
        end
    end

    always_comb
    begin
        drive_d.enable = enable_d;
        // level held low while driver off
        drive_d.level  = (level_d ^ invert_d) & enable_d;
    end

    // pins fed from next-state so they change with the register edge
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            o_pin_oe  <= RST_BYTE;
            o_pin_out <= RST_BYTE;
        end
        else
        begin
            o_pin_oe  <= drive_d.enable;
            o_pin_out <= drive_d.level;
        end
    end

    // input buffer from sense bits only
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            o_in_buf_en  <= RST_BYTE;
            o_pin_sample <= RST_BYTE;
        end
        else
        begin
            o_in_buf_en <= sense_en_q;
            for (int i = 0; i < PIN_COUNT; i++)
            begin
                if (sense_en_q[i])
                begin
                    o_pin_sample[i] <= i_pin_in[i] ^ invert_q[i];
                end
            end
        end
    end

    enable_set_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_req.wr && i_req.addr == OFS_ENABLE_SET
        |=> (enable_q & $past(i_req.wdata)) == $past(i_req.wdata))
        else $error("enable set bits not raised");

    enable_clear_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_req.wr && i_req.addr == OFS_ENABLE_CLEAR
        |=> (enable_q & $past(i_req.wdata)) == 8'h00)
        else $error("enable clear bits not dropped");

    enable_toggle_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_req.wr && i_req.addr == OFS_ENABLE_TOGGLE
        |=> enable_q == ($past(enable_q) ^ $past(i_req.wdata)))
        else $error("enable toggle wrong");

    zero_untouched_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_req.wr && i_req.addr == OFS_LEVEL_SET
        |=> (level_q & ~$past(i_req.wdata))
            == ($past(level_q) & ~$past(i_req.wdata)))
        else $error("level set touched zero bits");

    level_clear_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_req.wr && i_req.addr == OFS_LEVEL_CLEAR
        |=> level_q == ($past(level_q) & ~$past(i_req.wdata)))
        else $error("level clear wrong");

    level_toggle_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_req.wr && i_req.addr == OFS_LEVEL_TOGGLE
        |=> level_q == ($past(level_q) ^ $past(i_req.wdata)))
        else $error("level toggle wrong");

    enable_read_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_req.rd && i_req.addr == OFS_ENABLE_TOGGLE
        |=> o_rdata == $past(enable_q))
        else $error("enable alias read wrong");

    level_read_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_req.rd && i_req.addr == OFS_LEVEL_CLEAR
        |=> o_rdata == $past(level_q))
        else $error("level alias read wrong");

    pin_gated_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (o_pin_out & ~o_pin_oe) == 8'h00)
        else $error("level driven with driver off");

    pin_follows_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_pin_oe == enable_q
        && o_pin_out == ((level_q ^ invert_q) & enable_q))
        else $error("pins do not follow registers");

    level_set_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        i_req.wr && i_req.addr == OFS_LEVEL_SET
        |=> (level_q & $past(i_req.wdata)) == $past(i_req.wdata))
        else $error("level set bits not raised");

    enable_keep_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        i_req.wr && i_req.addr == OFS_ENABLE_SET
        |=> (enable_q & ~$past(i_req.wdata))
            == ($past(enable_q) & ~$past(i_req.wdata)))
        else $error("enable set touched zero bits");

    clear_keep_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        i_req.wr && i_req.addr == OFS_ENABLE_CLEAR
        |=> (enable_q | $past(i_req.wdata))
            == ($past(enable_q) | $past(i_req.wdata)))
        else $error("enable clear touched zero bits");

    enable_write_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        i_req.wr && i_req.addr == OFS_DRIVE_ENABLE
        |=> enable_q == $past(i_req.wdata))
        else $error("enable write not stored");

    level_write_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        i_req.wr && i_req.addr == OFS_DRIVE_LEVEL
        |=> level_q == $past(i_req.wdata))
        else $error("level write not stored");

    regs_hold_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        !i_req.wr
        |=> enable_q == $past(enable_q) && level_q == $past(level_q))
        else $error("registers moved without a write");

    invert_write_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        i_req.wr && i_req.addr == OFS_POLARITY_INVERT
        |=> invert_q == $past(i_req.wdata))
        else $error("invert write not stored");

    sense_write_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        i_req.wr && i_req.addr == OFS_INPUT_SENSE_EN
        |=> sense_en_q == $past(i_req.wdata))
        else $error("sense write not stored");

    set_read_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        i_req.rd && i_req.addr == OFS_ENABLE_SET
        |=> o_rdata == $past(enable_q))
        else $error("enable set alias read wrong");

    level_read_set_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        i_req.rd && i_req.addr == OFS_LEVEL_SET
        |=> o_rdata == $past(level_q))
        else $error("level set alias read wrong");

    read_toggle_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        i_req.rd && i_req.addr == OFS_LEVEL_TOGGLE
        |=> o_rdata == $past(level_q))
        else $error("level toggle alias read wrong");

    buffer_follow_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        1'b1
        |=> o_in_buf_en == $past(sense_en_q))
        else $error("input buffer not from sense bits");

    sample_invert_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        1'b1
        |=> ((o_pin_sample ^ $past(i_pin_in) ^ $past(invert_q))
            & $past(sense_en_q)) == 8'h00)
        else $error("sampled pin value wrong");

    sample_hold_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        1'b1
        |=> ((o_pin_sample ^ $past(o_pin_sample))
            & ~$past(sense_en_q)) == 8'h00)
        else $error("sample moved with buffer off");
endmodule

/* File: tb/pin_wire_model.sv */
// Purpose: external pin wires seen by the port drive block
// Assumes: undriven pins follow the external pattern from the bench
// Notes:   no pull-ups; a released pin shows what outside drives
`timescale 1ns/1ps
module pin_wire_model
(
    input  wire logic [7:0] i_out,
    input  wire logic [7:0] i_oe,
    input  wire logic [7:0] i_ext,
    output logic      [7:0] o_pin
);
    always_comb
    begin
        o_pin = (i_out & i_oe) | (i_ext & ~i_oe);
    end
endmodule

/* File: tb/gpio_port_drive_regs_tb.sv */
// Purpose: self-checking bench for the port drive registers
// Assumes: plain register port, read data one cycle after strobe
// Notes:   external pattern differs from driven levels on purpose
`timescale 1ns/1ps
module gpio_port_drive_regs_tb;
    import gpio_drive_pkg::*;
    logic       i_clk   = 1'b0;
    logic       i_rst_n = 1'b0;
    reg_req_t   req     = '0;
    logic [7:0] ext     = 8'h00;
    logic [7:0] rdata, pout, poe, bufen, samp, pin;
    int         n_fail  = 0;
    int         checked = 0;
    int         cycles  = 0;

    always #2 i_clk = ~i_clk;

    gpio_port_drive_regs dut (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_req(req), .i_pin_in(pin), .o_rdata(rdata), .o_pin_out(pout),
        .o_pin_oe(poe), .o_in_buf_en(bufen), .o_pin_sample(samp));
    pin_wire_model pins (.i_out(pout), .i_oe(poe), .i_ext(ext),
        .o_pin(pin));

    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        checked++;
        if (g !== e)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge i_clk);
        req.addr  <= a;
        req.wdata <= d;
        req.wr    <= 1'b1;
        @(posedge i_clk);
        req.wr    <= 1'b0;
        @(negedge i_clk);
    endtask

    task automatic rd_chk(input logic [4:0] a, input logic [7:0] e);
        @(posedge i_clk);
        req.addr <= a;
        req.rd   <= 1'b1;
        @(posedge i_clk);
        req.rd   <= 1'b0;
        @(negedge i_clk);
        chk("rdata", e, rdata);
    endtask

    task automatic t_reset();
        for (int i = 0; i < 8; i++)
            rd_chk(5'(i), RST_BYTE);
        chk("oe", 8'h00, poe);
        chk("out", 8'h00, pout);
    endtask

    task automatic t_enable();
        wr(OFS_ENABLE_SET, 8'h81);
        rd_chk(OFS_ENABLE_SET, 8'h81);
        chk("oe", 8'h81, poe);
        wr(OFS_ENABLE_CLEAR, 8'h01);
        rd_chk(OFS_ENABLE_CLEAR, 8'h80);
        wr(OFS_ENABLE_TOGGLE, 8'h0f);
        rd_chk(OFS_ENABLE_TOGGLE, 8'h8f);
        wr(OFS_ENABLE_SET, 8'h00);
        wr(OFS_ENABLE_CLEAR, 8'h00);
        wr(OFS_ENABLE_TOGGLE, 8'h00);
        rd_chk(OFS_DRIVE_ENABLE, 8'h8f);
        wr(OFS_DRIVE_ENABLE, 8'h3c);
        chk("oe", 8'h3c, poe);
    endtask

    task automatic t_level();
        wr(OFS_LEVEL_SET, 8'hf0);
        rd_chk(OFS_LEVEL_SET, 8'hf0);
        chk("out", 8'h30, pout);
        wr(OFS_LEVEL_CLEAR, 8'h10);
        rd_chk(OFS_LEVEL_CLEAR, 8'he0);
        wr(OFS_LEVEL_TOGGLE, 8'h03);
        rd_chk(OFS_LEVEL_TOGGLE, 8'he3);
        chk("out", 8'h20, pout);
        wr(OFS_LEVEL_SET, 8'h00);
        wr(OFS_LEVEL_CLEAR, 8'h00);
        wr(OFS_LEVEL_TOGGLE, 8'h00);
        rd_chk(OFS_DRIVE_LEVEL, 8'he3);
        wr(OFS_DRIVE_LEVEL, 8'h5a);
        chk("out", 8'h18, pout);
    endtask

    task automatic t_invert_sense();
        ext <= 8'hc3;
        wr(OFS_POLARITY_INVERT, 8'h0f);
        chk("out", 8'h14, pout);
        chk("bufen", 8'h00, bufen);
        chk("samp", 8'h00, samp);
        wr(OFS_INPUT_SENSE_EN, 8'hff);
        repeat (3) @(negedge i_clk);
        chk("bufen", 8'hff, bufen);
        chk("samp", 8'hd8, samp);
        wr(5'h1f, 8'hff);
        rd_chk(5'h1f, UNMAPPED_RD);
        chk("oe", 8'h3c, poe);
    endtask

    task automatic finish_test();
        if (n_fail == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ceiling well above the roughly 80 cycles the run needs
    always @(posedge i_clk)
    begin
        cycles++;
        if (cycles > 2000)
        begin
            n_fail++;
            finish_test();
        end
    end

    initial
    begin
        repeat (6) @(posedge i_clk);
        i_rst_n <= 1'b1;
        t_reset();
        t_enable();
        t_level();
        t_invert_sense();
        finish_test();
    end
endmodule
